/* File: acdr_host_model.sv */
`timescale 1ns/10ps
// host side master clock source, given as tick levels
module acdr_host_model (
  input wire logic mclk,
  input wire logic run,
  output logic osc_tick,
  output logic ext_tick
);
  logic [1:0] phase = 2'h0;
  // free running clocks; the pin clock runs at half the oscillator rate so selection shows
  always @(posedge mclk) begin
    phase <= run ? phase + 2'h1 : 2'h0;
  end
  assign osc_tick = phase[0];
  assign ext_tick = phase[1];
endmodule

/* File: acdr_pkg.sv */
package acdr_pkg;
  localparam logic [11:0] ACDR_CONFIG_ADDR = 12'h000;
  localparam logic [11:0] ACDR_STATUS_ADDR = 12'h004;
  localparam logic [11:0] ACDR_IRQ_EN_ADDR = 12'h008;
  localparam logic [11:0] ACDR_IRQ_CLR_ADDR = 12'h00c;
  localparam logic [11:0] ACDR_COUNT_ADDR = 12'h010;
  // configuration field positions
  localparam int ACDR_PRE_LSB = 0;
  localparam int ACDR_OSR_LSB = 2;
  localparam int ACDR_EXT_BIT = 5;
  localparam logic [1:0] ACDR_PRE_RESET = 2'h0;
  localparam logic [2:0] ACDR_OSR_RESET = 3'h3;
  localparam logic ACDR_EXT_RESET = 1'b0;
  localparam logic [1:0] ACDR_DIV4_LAST = 2'h3;
  localparam logic [1:0] ACDR_DIV4_HALF = 2'h2;
  localparam logic [11:0] ACDR_OSR_BASE = 12'h01f;
  localparam int ACDR_NUM_EVENTS = 2;
  localparam int ACDR_EV_DATA = 0;
  localparam int ACDR_EV_OVERRUN = 1;
  typedef struct packed {
    logic ext_sel;
    logic [2:0] osr;
    logic [1:0] pre;
  } acdr_cfg_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } acdr_apb_req_t;
endpackage

/* File: acdr_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser; first stage feeds only the second
module acdr_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta;
  logic next_meta;
  logic next_q;
  // plain pass-through of the stages
  always_comb begin
    next_meta = d;
    next_q = meta;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

/* File: acdr_top.sv */
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// clock divider and data-ready generator, one clock domain
module acdr_top (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic OSC_TICK,
  input wire logic EXT_CLK_TICK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic ANALOG_SIDE_CLOCK,
  output logic SAMPLE_RATE_CLOCK,
  output logic OUTPUT_RATE_STROBE,
  output logic CONVERSION_READY_N,
  output logic IRQ
);
  logic pin_rst_s;
  logic osc_s;
  logic ext_s;
  logic chip_rst;
  acdr_pkg::acdr_cfg_t cfg;
  acdr_pkg::acdr_cfg_t next_cfg;
  acdr_pkg::acdr_apb_req_t req;
  logic [2:0] pre_cnt;
  logic [2:0] next_pre_cnt;
  logic [1:0] div4;
  logic [1:0] next_div4;
  logic [11:0] osr_cnt;
  logic [11:0] next_osr_cnt;
  logic [11:0] osr_last;
  logic [2:0] pre_last;
  logic master_tick;
  logic master_prev;
  logic next_master_prev;
  logic analog_side_clock_tick;
  logic next_analog_side_clock;
  logic next_smclk;
  logic next_strobe;
  logic next_ready_n;
  logic low_active;
  logic next_low_active;
  logic [acdr_pkg::ACDR_NUM_EVENTS-1:0] status;
  logic [acdr_pkg::ACDR_NUM_EVENTS-1:0] next_status;
  logic [acdr_pkg::ACDR_NUM_EVENTS-1:0] irq_en;
  logic [acdr_pkg::ACDR_NUM_EVENTS-1:0] next_irq_en;
  logic [acdr_pkg::ACDR_NUM_EVENTS-1:0] events;
  logic [acdr_pkg::ACDR_NUM_EVENTS-1:0] clr_mask;
  logic [15:0] strobe_count;
  logic [15:0] next_strobe_count;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic access;

  // pins from outside the domain pass two flops first
  // the asserted level is synced so the flops' reset value means "not in reset"
  // and the chip answers at once after power-on release
  acdr_sync u_sync_rst (.clk(MCLK), .rst(RST), .d(~RESET_N), .q(pin_rst_s));
  acdr_sync u_sync_osc (.clk(MCLK), .rst(RST), .d(OSC_TICK), .q(osc_s));
  acdr_sync u_sync_ext (.clk(MCLK), .rst(RST), .d(EXT_CLK_TICK), .q(ext_s));

  assign chip_rst = pin_rst_s;
  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

  // master source select; rising edge of chosen source is one master tick
  always_comb begin
    next_master_prev = cfg.ext_sel ? ext_s : osc_s;
    master_tick = next_master_prev & ~master_prev;
  end

  always_comb begin
    case (cfg.pre)
      2'h0: pre_last = 3'h0;
      2'h1: pre_last = 3'h1;
      2'h2: pre_last = 3'h3;
      default: pre_last = 3'h7;
    endcase
  end

  // ratio doubles from 32 per code step
  assign osr_last = ((acdr_pkg::ACDR_OSR_BASE + 12'h001) << cfg.osr) - 12'h001;

  // divider chain; reset holds every counter at zero
  always_comb begin
    next_pre_cnt = pre_cnt;
    next_div4 = div4;
    next_osr_cnt = osr_cnt;
    next_strobe = 1'b0;
    next_low_active = low_active;
    analog_side_clock_tick = 1'b0;
    events = '0;
    if (chip_rst) begin
      next_pre_cnt = '0;
      next_div4 = '0;
      next_osr_cnt = '0;
      next_low_active = 1'b0;
    end else if (master_tick) begin
      if (pre_cnt >= pre_last) begin
        next_pre_cnt = '0;
        analog_side_clock_tick = 1'b1;
      end else begin
        next_pre_cnt = pre_cnt + 3'h1;
      end
      if (analog_side_clock_tick) begin
        next_div4 = div4 + 2'h1;
        // release on the tick that enters the low half, two ticks after the strobe
        if (next_div4 == acdr_pkg::ACDR_DIV4_HALF) begin
          next_low_active = 1'b0;
        end
        if (div4 == acdr_pkg::ACDR_DIV4_LAST) begin
          if (osr_cnt >= osr_last) begin
            next_osr_cnt = '0;
            next_strobe = 1'b1;
            events[acdr_pkg::ACDR_EV_DATA] = 1'b1;
            events[acdr_pkg::ACDR_EV_OVERRUN] = status[acdr_pkg::ACDR_EV_DATA];
            next_low_active = 1'b1;
          end else begin
            next_osr_cnt = osr_cnt + 12'h001;
          end
        end
      end
    end
  end

  // low for half a sample period, two analog ticks
  always_comb begin
    next_ready_n = ~next_low_active;
    next_analog_side_clock = chip_rst ? 1'b0 : (analog_side_clock_tick ? ~ANALOG_SIDE_CLOCK : ANALOG_SIDE_CLOCK);
    next_smclk = chip_rst ? 1'b0 : ~next_div4[1];
  end

  // apb slave; answers in the access cycle with no wait
  always_comb begin
    access = req.psel & req.penable;
    next_cfg = cfg;
    next_irq_en = irq_en;
    clr_mask = '0;
    next_prdata = '0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_strobe_count = strobe_count;
    if (next_strobe) begin
      next_strobe_count = strobe_count + 16'h0001;
    end
    if (req.psel & ~req.penable) begin
      next_pready = 1'b1;
      if (chip_rst) begin
        next_pslverr = 1'b1;
      end else if (req.paddr == acdr_pkg::ACDR_CONFIG_ADDR) begin
        next_prdata = {26'h0, cfg};
      end else if (req.paddr == acdr_pkg::ACDR_STATUS_ADDR) begin
        next_prdata = {30'h0, status};
      end else if (req.paddr == acdr_pkg::ACDR_IRQ_EN_ADDR) begin
        next_prdata = {30'h0, irq_en};
      end else if (req.paddr == acdr_pkg::ACDR_IRQ_CLR_ADDR) begin
        next_prdata = '0;
      end else if (req.paddr == acdr_pkg::ACDR_COUNT_ADDR) begin
        next_prdata = {16'h0, strobe_count};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (access & PREADY & ~PSLVERR & req.pwrite & ~chip_rst) begin
      if (req.paddr == acdr_pkg::ACDR_CONFIG_ADDR) begin
        next_cfg.pre = req.pwdata[acdr_pkg::ACDR_PRE_LSB +: 2];
        next_cfg.osr = req.pwdata[acdr_pkg::ACDR_OSR_LSB +: 3];
        next_cfg.ext_sel = req.pwdata[acdr_pkg::ACDR_EXT_BIT];
      end else if (req.paddr == acdr_pkg::ACDR_IRQ_EN_ADDR) begin
        next_irq_en = req.pwdata[acdr_pkg::ACDR_NUM_EVENTS-1:0];
      end else if (req.paddr == acdr_pkg::ACDR_IRQ_CLR_ADDR) begin
        clr_mask = req.pwdata[acdr_pkg::ACDR_NUM_EVENTS-1:0];
      end
    end
    if (chip_rst) begin
      next_cfg = '{ext_sel: acdr_pkg::ACDR_EXT_RESET, osr: acdr_pkg::ACDR_OSR_RESET, pre: acdr_pkg::ACDR_PRE_RESET};
      next_irq_en = '0;
      next_strobe_count = '0;
    end
  end

  // sticky status: set beats clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < acdr_pkg::ACDR_NUM_EVENTS; gi++) begin : g_stat
      always_comb begin
        if (chip_rst) begin
          next_status[gi] = 1'b0;
        end else if (events[gi]) begin
          next_status[gi] = 1'b1;
        end else if (clr_mask[gi]) begin
          next_status[gi] = 1'b0;
        end else begin
          next_status[gi] = status[gi];
        end
      end
    end
  endgenerate

  assign next_irq = |(next_status & next_irq_en);

  // no extra startup delay after release
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg <= '{ext_sel: acdr_pkg::ACDR_EXT_RESET, osr: acdr_pkg::ACDR_OSR_RESET, pre: acdr_pkg::ACDR_PRE_RESET};
      irq_en <= '0;
      status <= '0;
      strobe_count <= '0;
      pre_cnt <= '0;
      div4 <= '0;
      osr_cnt <= '0;
      master_prev <= 1'b0;
      low_active <= 1'b0;
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      ANALOG_SIDE_CLOCK <= 1'b0;
      SAMPLE_RATE_CLOCK <= 1'b0;
      OUTPUT_RATE_STROBE <= 1'b0;
      CONVERSION_READY_N <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      cfg <= next_cfg;
      irq_en <= next_irq_en;
      status <= next_status;
      strobe_count <= next_strobe_count;
      pre_cnt <= next_pre_cnt;
      div4 <= next_div4;
      osr_cnt <= next_osr_cnt;
      master_prev <= next_master_prev;
      low_active <= next_low_active;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      ANALOG_SIDE_CLOCK <= next_analog_side_clock;
      SAMPLE_RATE_CLOCK <= next_smclk;
      OUTPUT_RATE_STROBE <= next_strobe;
      CONVERSION_READY_N <= next_ready_n;
      IRQ <= next_irq;
    end
  end
endmodule

/* File: acdr_top_monitor.sv */
`timescale 1ns/10ps
// outside view of the divider: answers, strobe, ready pin, pin reset
module acdr_top_monitor (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic ANALOG_SIDE_CLOCK,
  input wire logic SAMPLE_RATE_CLOCK,
  input wire logic OUTPUT_RATE_STROBE,
  input wire logic CONVERSION_READY_N,
  input wire logic IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // six low samples cover the pin synchroniser latency
  a_pin_refuses: assert property (!RESET_N [*6] ##0 PREADY |-> PSLVERR)
    else $error("access accepted during pin reset");
  a_pin_quiet: assert property (!RESET_N [*6] |-> !ANALOG_SIDE_CLOCK && !SAMPLE_RATE_CLOCK && !OUTPUT_RATE_STROBE)
    else $error("clocks running during pin reset");
  a_pin_state: assert property (!RESET_N [*6] |-> CONVERSION_READY_N && !IRQ)
    else $error("pin reset state differs from power-on");
  a_pin_release: assert property ($rose(RESET_N) |-> ##1 CONVERSION_READY_N && !OUTPUT_RATE_STROBE)
    else $error("activity right at pin release");
  // strobe, ready pulse and sample clock shape
  a_strobe_single: assert property (OUTPUT_RATE_STROBE |=> !OUTPUT_RATE_STROBE [*8])
    else $error("strobe longer than one cycle");
  a_strobe_ready: assert property (OUTPUT_RATE_STROBE |-> ##[0:1] !CONVERSION_READY_N)
    else $error("strobe without ready pulse");
  a_ready_cause: assert property ($fell(CONVERSION_READY_N) |-> OUTPUT_RATE_STROBE || $past(OUTPUT_RATE_STROBE))
    else $error("ready pulse without strobe");
  // shortest legal pulse is two ticks of two cycles each
  a_ready_width: assert property ($fell(CONVERSION_READY_N) |=> !CONVERSION_READY_N [*3])
    else $error("ready pulse too short");
  a_sample_high: assert property ($rose(SAMPLE_RATE_CLOCK) |=> SAMPLE_RATE_CLOCK)
    else $error("sample clock high phase too short");
  c_strobe: cover property (OUTPUT_RATE_STROBE);
  c_refused: cover property (PREADY && PSLVERR);
  c_irq: cover property ($rose(IRQ));
endmodule

bind acdr_top acdr_top_monitor acdr_top_monitor_inst (.*);

/* File: acdr_top_tb_top.sv */
`timescale 1ns/10ps
// apb tasks, rate table timing, irq and pin reset sequences
module acdr_top_tb_top;
  logic MCLK = 1'b0, RST = 1'b1, RESET_N = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, OSC_TICK, EXT_CLK_TICK, ANALOG_SIDE_CLOCK, SAMPLE_RATE_CLOCK;
  logic OUTPUT_RATE_STROBE, CONVERSION_READY_N, IRQ, er, ac;
  logic [7:0] cfgs [10] = '{8'h20, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  int failures = 0, samples_checked = 0, p, w, n, t;
  time t0;
  acdr_top acdr_top_inst (.*);
  acdr_host_model acdr_host_model_inst (.mclk(MCLK), .run(1'b1), .osc_tick(OSC_TICK), .ext_tick(EXT_CLK_TICK));
  // 50 ns period
  initial forever #25 MCLK = ~MCLK;
  // request held until ready is seen high at a rising edge; answer taken at that edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do @(posedge MCLK); while (PREADY !== 1'b1 && n++ < 64);
    if (PREADY !== 1'b1) begin
      failures++;
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // compare and count
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for the next strobe
  task strobe_wait;
    n = 0;
    do @(negedge MCLK); while (OUTPUT_RATE_STROBE !== 1'b1 && n++ < 20000);
    if (OUTPUT_RATE_STROBE !== 1'b1) begin
      failures++;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // slowest table entry dominates; twice the expected run
  initial begin
    repeat (90000) @(posedge MCLK);
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check("config", rd, 32'h0000000c);
    apb(1'b1, 12'h008, 32'h1);
    strobe_wait;
    repeat (3) @(negedge MCLK);
    check("irq set", 32'(IRQ), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("status", rd, 32'h1);
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h008, 32'h0);
    repeat (2) @(negedge MCLK);
    check("irq clear", 32'(IRQ), 32'h0);
    strobe_wait;
    repeat (3) @(negedge MCLK);
    check("irq mask", 32'(IRQ), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", 32'(er), 32'h1);
    $display("test irq done");
    // table ascends in osr code so a new osr terminal count is never passed
    foreach (cfgs[i]) begin
      apb(1'b1, 12'h000, {24'h0, cfgs[i]});
      strobe_wait;
      p = 0;
      w = 0;
      t = 0;
      ac = ANALOG_SIDE_CLOCK;
      do begin
        @(negedge MCLK);
        p++;
        w += (CONVERSION_READY_N === 1'b0);
        t += (ANALOG_SIDE_CLOCK !== ac);
        ac = ANALOG_SIDE_CLOCK;
      end while (OUTPUT_RATE_STROBE !== 1'b1 && p < 40000);
      check("analog ticks", t, 4 * (32 << cfgs[i][4:2]));
      check("period", p, (cfgs[i][5] ? 4 : 2) * (4 << cfgs[i][1:0]) * (32 << cfgs[i][4:2]));
      check("width", w, (cfgs[i][5] ? 4 : 2) * (2 << cfgs[i][1:0]));
    end
    apb(1'b0, 12'h004, 32'h0);
    check("overrun", rd, 32'h3);
    $display("test rates done");
    @(posedge MCLK);
    RESET_N <= 1'b0;
    repeat (8) @(negedge MCLK);
    apb(1'b0, 12'h000, 32'h0);
    check("held", 32'(er), 32'h1);
    @(posedge MCLK);
    RESET_N <= 1'b1;
    t0 = $time;
    repeat (4) @(negedge MCLK);
    apb(1'b0, 12'h000, 32'h0);
    check("pin reset", rd, 32'h0000000c);
    strobe_wait;
    // first strobe one full default period, plus sync delay
    check("first", 32'(($time - t0) / 50 inside {[2048:2060]}), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check("count", rd, 32'h1);
    $display("test reset done");
    tally_and_finish;
  end
endmodule
